// *** design/vpm_access_check.sv ***
// vpm_access_check: decides how a system register access to a map register resolves
// assumes: driven by the top through vpm_ctl_if, no state of its own
`timescale 1ns/1ns
module vpm_access_check (
	// decision port
	vpm_ctl_if.chk ctl
);
	logic present;
	logic trap_to_el3;

	always_comb begin
		// a register n exists when the reported highest index reaches n
		present = ctl.feature_present && ctl.hyp_control_present
			&& (ctl.highest_map_reg_index >= ctl.reg_index)
			&& (ctl.highest_map_reg_index <= vpm_pkg::MAX_REG_INDEX);
		trap_to_el3 = ctl.el3_present && ctl.trap_lower_levels;
		ctl.nested_virt_memory_area_offset = vpm_pkg::NESTED_VIRT_MEMORY_AREA_BASE
			+ 12'(ctl.reg_index) * vpm_pkg::NESTED_VIRT_MEMORY_AREA_STRIDE;
		ctl.result = vpm_pkg::VPM_RES_UNDEF;
		if (!present) begin
			ctl.result = vpm_pkg::VPM_RES_UNDEF;
		end else begin
			unique case (ctl.el)
				vpm_pkg::VPM_EL0: begin
					ctl.result = vpm_pkg::VPM_RES_UNDEF;
				end
				vpm_pkg::VPM_EL1: begin
					if (ctl.el2_enabled && ctl.nv && ctl.nv2) begin
						ctl.result = vpm_pkg::VPM_RES_NESTED_VIRT_MEMORY_AREA;
					end else if (ctl.el2_enabled && ctl.nv) begin
						if (trap_to_el3) begin
							ctl.result = (ctl.halted && ctl.secure_debug_disable)
								? vpm_pkg::VPM_RES_UNDEF
								: vpm_pkg::VPM_RES_TRAP_EL3;
						end else begin
							ctl.result = vpm_pkg::VPM_RES_TRAP_EL2;
						end
					end else begin
						ctl.result = vpm_pkg::VPM_RES_UNDEF;
					end
				end
				vpm_pkg::VPM_EL2: begin
					if (trap_to_el3) begin
						ctl.result = (ctl.halted && ctl.secure_debug_disable)
							? vpm_pkg::VPM_RES_UNDEF
							: vpm_pkg::VPM_RES_TRAP_EL3;
					end else begin
						ctl.result = vpm_pkg::VPM_RES_OK;
					end
				end
				vpm_pkg::VPM_EL3: begin
					ctl.result = vpm_pkg::VPM_RES_OK;
				end
			endcase
		end
	end
endmodule

// *** design/vpm_map_regs.sv ***
// vpm_map_regs: virtual to physical partition id map registers with access checking
// assumes: core presents one system register access per cycle, answer one cycle later;
// hypervisor control and validity registers live elsewhere and arrive as inputs
`timescale 1ns/1ns
module vpm_map_regs (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	// configuration
	input wire logic feature_present,
	input wire logic hyp_control_present,
	input wire logic [2:0] highest_map_reg_index,
	input wire logic el3_present,
	// state of the core
	input wire logic [1:0] current_el,
	input wire logic el2_enabled,
	input wire logic nested_virt_control,
	input wire logic nested_virt_memory_redirect,
	input wire logic trap_lower_levels,
	input wire logic halted,
	input wire logic secure_debug_disable,
	// system register access
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic [2:0] acc_index,
	input wire logic [63:0] acc_wdata,
	output logic resp_valid,
	output logic [2:0] resp_result,
	output logic [63:0] resp_rdata,
	output logic [11:0] resp_nested_virt_memory_area_offset,
	output logic [5:0] resp_trap_class,
	// translation
	input wire logic [31:0] map_entry_valid_bits,
	input wire logic el1_translation_enable,
	input wire logic el0_translation_enable,
	input wire logic xlate_from_el1,
	input wire logic [4:0] xlate_virtual_id,
	output logic [15:0] xlate_physical_id,
	output logic xlate_hit
);
	vpm_ctl_if ctl ();
	logic [63:0] map_regs [8];
	logic [15:0] next_phys;
	logic next_hit;
	logic acc_present;
	logic el3_trap;
	logic sdd_block;

	////////////////////////////////////////////////////////////////
	// access decision
	assign ctl.reg_index = acc_index;
	assign ctl.el = vpm_pkg::vpm_el_t'(current_el);
	assign ctl.el2_enabled = el2_enabled;
	assign ctl.nv = nested_virt_control;
	assign ctl.nv2 = nested_virt_memory_redirect;
	assign ctl.el3_present = el3_present;
	assign ctl.trap_lower_levels = trap_lower_levels;
	assign ctl.halted = halted;
	assign ctl.secure_debug_disable = secure_debug_disable;
	assign ctl.feature_present = feature_present;
	assign ctl.hyp_control_present = hyp_control_present;
	assign ctl.highest_map_reg_index = highest_map_reg_index;

	vpm_access_check u_check (
		.ctl(ctl)
	);

	////////////////////////////////////////////////////////////////
	// map storage: no reset, so contents are unknown after warm reset
	always_ff @(posedge clock) begin
		if (clk_en && acc_valid && acc_write
			&& ctl.result == vpm_pkg::VPM_RES_OK) begin
			map_regs[acc_index] <= acc_wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// response
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			resp_valid <= 1'b0;
			resp_result <= 3'h0;
			resp_nested_virt_memory_area_offset <= 12'h000;
			resp_trap_class <= 6'h00;
		end else if (clk_en) begin
			resp_valid <= acc_valid;
			resp_result <= ctl.result;
			// redirected access: core does the memory transfer at this offset
			resp_nested_virt_memory_area_offset <= (ctl.result == vpm_pkg::VPM_RES_NESTED_VIRT_MEMORY_AREA)
				? ctl.nested_virt_memory_area_offset : 12'h000;
			resp_trap_class <= (ctl.result == vpm_pkg::VPM_RES_TRAP_EL2
				|| ctl.result == vpm_pkg::VPM_RES_TRAP_EL3)
				? vpm_pkg::TRAP_CLASS : 6'h00;
		end
	end

	// read data has no reset either; only meaningful with an ok read
	always_ff @(posedge clock) begin
		if (clk_en) begin
			resp_rdata <= (acc_valid && !acc_write && ctl.result == vpm_pkg::VPM_RES_OK)
				? map_regs[acc_index] : 64'h0000_0000_0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////
	// translation
	vpm_translate u_xlate (
		.map_regs(map_regs),
		.valid_bits(map_entry_valid_bits),
		.highest_map_reg_index(highest_map_reg_index),
		.el2_enabled(el2_enabled),
		.el1_translation_enable(el1_translation_enable),
		.el0_translation_enable(el0_translation_enable),
		.source_is_el1(xlate_from_el1),
		.virtual_id(xlate_virtual_id),
		.physical_id(next_phys),
		.hit(next_hit)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			xlate_physical_id <= 16'h0000;
			xlate_hit <= 1'b0;
		end else if (clk_en) begin
			xlate_physical_id <= next_phys;
			xlate_hit <= next_hit;
		end
	end

	////////////////////////////////////////////////////////////////
	// check helpers: decision inputs restated apart from the checker module
	assign acc_present = feature_present && hyp_control_present
		&& (acc_index <= highest_map_reg_index);
	assign el3_trap = el3_present && trap_lower_levels;
	assign sdd_block = halted && secure_debug_disable;

	////////////////////////////////////////////////////////////////
	// checks
	AST_EL0_UNDEF: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && current_el == 2'b00 |=> resp_result == 3'b001)
		else $error("el0 access not undefined");
	AST_SIX_ABSENT: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && acc_index == 3'h6 && highest_map_reg_index <= 3'h5
		|=> resp_result == 3'b001)
		else $error("absent register six accessed");
	AST_NV_REDIRECT: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && acc_index == 3'h5 && current_el == 2'b01
		&& el2_enabled && nested_virt_control && nested_virt_memory_redirect
		&& feature_present && hyp_control_present && highest_map_reg_index >= 3'h5
		|=> resp_result == 3'b100 && resp_nested_virt_memory_area_offset == 12'h968)
		else $error("nested redirect offset wrong");
	AST_TRAP_CLASS: assert property (@(posedge clock) disable iff (rst)
		clk_en && resp_valid && (resp_result == 3'b010 || resp_result == 3'b011)
		|-> resp_trap_class == 6'h18)
		else $error("trap class wrong");
	AST_SDD_UNDEF: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && current_el == 2'b10 && el3_present && trap_lower_levels
		&& halted && secure_debug_disable |=> resp_result == 3'b001)
		else $error("halted secure debug not undefined");
	AST_READ_BACK: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && acc_write && acc_index == 3'h6 && ctl.result == 3'b000
		##1 clk_en && acc_valid && !acc_write && acc_index == 3'h6
		&& ctl.result == 3'b000 |=> resp_rdata == $past(acc_wdata, 2))
		else $error("read back mismatch");
	AST_NO_EL2_NO_HIT: assert property (@(posedge clock) disable iff (rst)
		clk_en && !el2_enabled |=> !xlate_hit)
		else $error("translation without el2");
	AST_INVALID_NO_HIT: assert property (@(posedge clock) disable iff (rst)
		clk_en && !map_entry_valid_bits[xlate_virtual_id] |=> !xlate_hit)
		else $error("invalid entry hit");
	AST_SIX_FIELD: assert property (@(posedge clock) disable iff (rst)
		clk_en && next_hit && xlate_virtual_id == 5'h1b
		|=> xlate_physical_id == $past(map_regs[6][63:48]))
		else $error("entry 27 field wrong");

	////////////////////////////////////////////////////////////////
	// access decision checks, at least one per branch of the decision except the el2 halted secure debug branch
	AST_ABSENT_UNDEF: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && !acc_present
		|=> resp_result == 3'b001)
		else $error("absent map register accessed");
	AST_ZERO_ONLY: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && highest_map_reg_index == 3'h0 && acc_index != 3'h0
		|=> resp_result == 3'b001)
		else $error("register above zero present with index zero");
	AST_EL0_QUIET: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && current_el == 2'b00
		|=> resp_trap_class == 6'h00 && resp_nested_virt_memory_area_offset == 12'h000
		&& resp_rdata == 64'h0000_0000_0000_0000)
		else $error("el0 access left a side effect");
	AST_EL1_NO_EL2: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && acc_present && current_el == 2'b01 && !el2_enabled
		|=> resp_result == 3'b001)
		else $error("el1 access without el2 not undefined");
	AST_EL1_NO_NV: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && acc_present && current_el == 2'b01 && el2_enabled
		&& !nested_virt_control
		|=> resp_result == 3'b001)
		else $error("el1 access without nested control not undefined");
	AST_EL1_TRAP_EL2: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && acc_present && current_el == 2'b01 && el2_enabled
		&& nested_virt_control && !nested_virt_memory_redirect && !el3_trap
		|=> resp_result == 3'b010 && resp_trap_class == 6'h18)
		else $error("el1 nested access not trapped to el2");
	AST_EL1_TRAP_EL3: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && acc_present && current_el == 2'b01 && el2_enabled
		&& nested_virt_control && !nested_virt_memory_redirect && el3_trap && !sdd_block
		|=> resp_result == 3'b011 && resp_trap_class == 6'h18)
		else $error("el1 nested access not trapped to el3");
	AST_EL1_SDD_UNDEF: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && acc_present && current_el == 2'b01 && el2_enabled
		&& nested_virt_control && !nested_virt_memory_redirect && el3_trap && sdd_block
		|=> resp_result == 3'b001)
		else $error("el1 halted secure debug not undefined");
	AST_EL2_TRAP_EL3: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && acc_present && current_el == 2'b10 && el3_trap && !sdd_block
		|=> resp_result == 3'b011)
		else $error("el2 access not trapped to el3");
	AST_EL2_REACH: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && acc_present && current_el == 2'b10 && !el3_trap
		|=> resp_result == 3'b000)
		else $error("untrapped el2 access refused");
	AST_EL3_REACH: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && acc_present && current_el == 2'b11
		|=> resp_result == 3'b000)
		else $error("el3 access refused");
	AST_REDIRECT_SIX: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && acc_present && acc_index == 3'h6 && current_el == 2'b01
		&& el2_enabled && nested_virt_control && nested_virt_memory_redirect
		|=> resp_result == 3'b100 && resp_nested_virt_memory_area_offset == 12'h970)
		else $error("register six redirect offset wrong");

	////////////////////////////////////////////////////////////////
	// response field checks
	AST_OFFSET_IDLE: assert property (@(posedge clock) disable iff (rst)
		clk_en && resp_result != 3'b100
		|-> resp_nested_virt_memory_area_offset == 12'h000)
		else $error("offset shown without redirect");
	AST_CLASS_IDLE: assert property (@(posedge clock) disable iff (rst)
		clk_en && resp_result != 3'b010 && resp_result != 3'b011
		|-> resp_trap_class == 6'h00)
		else $error("trap class shown without trap");
	AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (rst)
		clk_en && !(acc_valid && !acc_write && ctl.result == vpm_pkg::VPM_RES_OK)
		|=> resp_rdata == 64'h0000_0000_0000_0000)
		else $error("read data shown without ok read");
	AST_READ_SIX: assert property (@(posedge clock) disable iff (rst)
		clk_en && acc_valid && !acc_write && acc_index == 3'h6
		&& ctl.result == vpm_pkg::VPM_RES_OK
		|=> resp_rdata == $past(map_regs[6]))
		else $error("register six read data wrong");

	////////////////////////////////////////////////////////////////
	// translation checks
	AST_EL1_GATE: assert property (@(posedge clock) disable iff (rst)
		clk_en && xlate_from_el1 && !el1_translation_enable
		|=> !xlate_hit)
		else $error("el1 id translated while disabled");
	AST_EL0_GATE: assert property (@(posedge clock) disable iff (rst)
		clk_en && !xlate_from_el1 && !el0_translation_enable
		|=> !xlate_hit)
		else $error("el0 id translated while disabled");
	AST_VALID_HIT: assert property (@(posedge clock) disable iff (rst)
		clk_en && el2_enabled && xlate_from_el1 && el1_translation_enable
		&& map_entry_valid_bits[xlate_virtual_id]
		&& xlate_virtual_id[4:2] <= highest_map_reg_index
		|=> xlate_hit)
		else $error("valid enabled entry missed");
	AST_BEYOND_HIGHEST: assert property (@(posedge clock) disable iff (rst)
		clk_en && xlate_virtual_id[4:2] > highest_map_reg_index
		|=> !xlate_hit)
		else $error("id beyond highest register translated");
	AST_MISS_ZERO: assert property (@(posedge clock) disable iff (rst)
		clk_en && !next_hit
		|=> xlate_physical_id == 16'h0000)
		else $error("physical id shown on a miss");
	AST_SIX_FIELD_24: assert property (@(posedge clock) disable iff (rst)
		clk_en && next_hit && xlate_virtual_id == 5'h18
		|=> xlate_physical_id == $past(map_regs[6][15:0]))
		else $error("entry 24 field wrong");
	AST_SIX_FIELD_25: assert property (@(posedge clock) disable iff (rst)
		clk_en && next_hit && xlate_virtual_id == 5'h19
		|=> xlate_physical_id == $past(map_regs[6][31:16]))
		else $error("entry 25 field wrong");
	AST_SIX_FIELD_26: assert property (@(posedge clock) disable iff (rst)
		clk_en && next_hit && xlate_virtual_id == 5'h1a
		|=> xlate_physical_id == $past(map_regs[6][47:32]))
		else $error("entry 26 field wrong");
endmodule

// *** design/vpm_translate.sv ***
// vpm_translate: picks the physical id for a virtual id from the map array
// assumes: map contents and controls come from the top, output is combinational
`timescale 1ns/1ns
module vpm_translate (
	// map state
	input wire logic [63:0] map_regs [8],
	input wire logic [31:0] valid_bits,
	input wire logic [2:0] highest_map_reg_index,
	// controls
	input wire logic el2_enabled,
	input wire logic el1_translation_enable,
	input wire logic el0_translation_enable,
	input wire logic source_is_el1,
	input wire logic [4:0] virtual_id,
	// result
	output logic [15:0] physical_id,
	output logic hit
);
	logic [2:0] reg_sel;
	logic [1:0] slot;
	logic enabled;
	logic [15:0] entries [4];

	assign reg_sel = virtual_id[4:2];
	assign slot = virtual_id[1:0];

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_slot
			assign entries[g] = map_regs[reg_sel][g*16 +: 16];
		end
	endgenerate

	always_comb begin
		// no translation at all without an enabled hypervisor level
		enabled = el2_enabled && (source_is_el1 ? el1_translation_enable
			: el0_translation_enable);
		hit = enabled && valid_bits[virtual_id]
			&& (reg_sel <= highest_map_reg_index);
		physical_id = hit ? entries[slot] : 16'h0000;
	end
endmodule

// *** include/vpm_ctl_if.sv ***
// vpm_ctl_if: carries the access decision between the top and the access checker
// assumes: one clock domain, purely combinational between the two modules
`timescale 1ns/1ns
interface vpm_ctl_if;
	logic [2:0] reg_index;
	vpm_pkg::vpm_el_t el;
	logic el2_enabled;
	logic nv;
	logic nv2;
	logic el3_present;
	logic trap_lower_levels;
	logic halted;
	logic secure_debug_disable;
	logic feature_present;
	logic hyp_control_present;
	logic [2:0] highest_map_reg_index;
	vpm_pkg::vpm_result_t result;
	logic [11:0] nested_virt_memory_area_offset;
	modport top (output reg_index, el, el2_enabled, nv, nv2, el3_present,
		trap_lower_levels, halted, secure_debug_disable, feature_present,
		hyp_control_present, highest_map_reg_index, input result, nested_virt_memory_area_offset);
	modport chk (input reg_index, el, el2_enabled, nv, nv2, el3_present,
		trap_lower_levels, halted, secure_debug_disable, feature_present,
		hyp_control_present, highest_map_reg_index, output result, nested_virt_memory_area_offset);
endinterface

// *** include/vpm_pkg.sv ***
// vpm_pkg: constants and types for the virtual partition id map register block
// assumes: included before the interface and design files
package vpm_pkg;
	localparam int ID_W = 16;
	localparam int REG_W = 64;
	localparam int NUM_REGS = 8;
	localparam int ENTRIES_PER_REG = 4;
	localparam int NUM_VIDS = 32;
	localparam logic [2:0] MAX_REG_INDEX = 3'h7;
	localparam logic [2:0] REG_FIVE = 3'h5;
	localparam logic [2:0] REG_SIX = 3'h6;
	localparam logic [2:0] SIX_PRESENT_ABOVE = 3'h5;
	localparam logic [2:0] FIVE_PRESENT_ABOVE = 3'h4;
	localparam logic [4:0] SIX_FIRST_VID = 5'h18;
	localparam logic [4:0] SIX_LAST_VID = 5'h1b;
	localparam logic [11:0] NESTED_VIRT_MEMORY_AREA_BASE = 12'h0940;
	localparam logic [11:0] NESTED_VIRT_MEMORY_AREA_STRIDE = 12'h0008;
	localparam logic [11:0] NESTED_VIRT_MEMORY_AREA_REG_FIVE = 12'h0968;
	localparam logic [5:0] TRAP_CLASS = 6'h18;
	localparam int ENTRY0_LSB = 0;
	localparam int ENTRY1_LSB = 16;
	localparam int ENTRY2_LSB = 32;
	localparam int ENTRY3_LSB = 48;
	localparam logic [63:0] REG_RESET = 64'h0000_0000_0000_0000;

	typedef enum logic [1:0] {
		VPM_EL0 = 2'b00,
		VPM_EL1 = 2'b01,
		VPM_EL2 = 2'b10,
		VPM_EL3 = 2'b11
	} vpm_el_t;

	typedef enum logic [2:0] {
		VPM_RES_OK = 3'b000,
		VPM_RES_UNDEF = 3'b001,
		VPM_RES_TRAP_EL2 = 3'b010,
		VPM_RES_TRAP_EL3 = 3'b011,
		VPM_RES_NESTED_VIRT_MEMORY_AREA = 3'b100
	} vpm_result_t;
endpackage

// *** tb/tb_vpm_map_regs.sv ***
// tb_vpm_map_regs: self-checking bench for the partition id map registers
// assumes: vpm_pkg, the design files and vpm_core_model are compiled first
`timescale 1ns/1ns
module tb_vpm_map_regs;
	localparam logic [63:0] W6 = 64'h1b1b_1a1a_1919_1818;
	logic clock, rst, ce, fp, hp, e3, e2, nv, nv2, tl, hl, sdd, e1en, e0en, fr1;
	logic [1:0] el;
	logic [2:0] hi;
	logic [4:0] vid;
	logic [31:0] vb;
	logic acc_valid, acc_write, resp_valid, hit;
	logic [2:0] acc_index, resp_result;
	logic [63:0] acc_wdata, resp_rdata;
	logic [11:0] nvoff;
	logic [5:0] tclass;
	logic [15:0] pid;
	int failures, compares;
	// {el, el2 on, nv, nv2, el3, trap lower, halted, sdd, write, index, result}
	logic [15:0] rows [11] = '{16'h0071, 16'h786c, 16'h782c, 16'h7673, 16'h7472,
		16'h77f1, 16'ha633, 16'ha470, 16'h5071, 16'he668, 16'ha7b1};
	vpm_map_regs dut (.clock(clock), .rst(rst), .clk_en(ce), .feature_present(fp),
		.hyp_control_present(hp), .highest_map_reg_index(hi), .el3_present(e3),
		.current_el(el), .el2_enabled(e2), .nested_virt_control(nv),
		.nested_virt_memory_redirect(nv2), .trap_lower_levels(tl), .halted(hl),
		.secure_debug_disable(sdd), .acc_valid(acc_valid), .acc_write(acc_write),
		.acc_index(acc_index), .acc_wdata(acc_wdata), .resp_valid(resp_valid),
		.resp_result(resp_result), .resp_rdata(resp_rdata), .resp_nested_virt_memory_area_offset(nvoff),
		.resp_trap_class(tclass), .map_entry_valid_bits(vb), .el1_translation_enable(e1en),
		.el0_translation_enable(e0en), .xlate_from_el1(fr1), .xlate_virtual_id(vid),
		.xlate_physical_id(pid), .xlate_hit(hit));
	vpm_core_model core (.clock(clock), .acc_valid(acc_valid), .acc_write(acc_write),
		.acc_index(acc_index), .acc_wdata(acc_wdata));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_dat(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_res(input logic [2:0] got, input logic [2:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		if (failures == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// one access, answer sampled at the falling edge after the taking edge
	task automatic acc(input logic w, input logic [2:0] i, input logic [2:0] r);
		core.issue(w, i, W6);
		chk_dat(resp_valid, 64'h1);
		chk_res(resp_result, r);
		chk_dat(nvoff, (r == 3'h4) ? 12'h0940 + 12'h0008 * i : 12'h0000);
		chk_dat(tclass, (r == 3'h2 || r == 3'h3) ? 6'h18 : 6'h00);
	endtask
	task automatic xl(input logic exp);
		@(negedge clock);
		chk_dat(hit, exp);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end
	initial begin
		#100000;
		failures++;
		wrap_up;
	end
	initial begin
		{rst, fp, hp, e3, e2, nv, nv2, tl, hl, sdd, e1en, e0en, fr1} = 13'h1fff;
		{el, hi, vid, vb} = '0;
		ce = 1'h1;
		hi = 3'h7;
		repeat (12) @(negedge clock);
		rst = 1'h0;
		chk_dat(resp_valid, 64'h0);
		foreach (rows[k]) begin
			{el, e2, nv, nv2, e3, tl, hl, sdd} = rows[k][15:7];
			acc(rows[k][6], rows[k][5:3], rows[k][2:0]);
			chk_dat(resp_rdata, 64'h0);
		end
		el = 2'h3;
		acc(1'h0, 3'h6, 3'h0);
		chk_dat(resp_rdata, W6);
		hi = 3'h5;
		acc(1'h0, 3'h6, 3'h1);
		hi = 3'h6;
		acc(1'h0, 3'h6, 3'h0);
		hi = 3'h0;
		acc(1'h0, 3'h5, 3'h1);
		acc(1'h0, 3'h0, 3'h0);
		hi = 3'h7;
		// frozen cycles: this write must not land
		ce = 1'h0;
		core.issue(1'h1, 3'h6, 64'h0000_0000_0000_0000);
		ce = 1'h1;
		acc(1'h0, 3'h6, 3'h0);
		chk_dat(resp_rdata, W6);
		core.pair(3'h6, ~W6);
		chk_res(resp_result, 3'h0);
		chk_dat(resp_rdata, ~W6);
		core.pair(3'h6, W6);
		chk_dat(resp_rdata, W6);
		// translation: entry 26 left invalid
		{e2, e1en, e0en, fr1} = 4'hd;
		vb = 32'h0b00_0000;
		for (int v = 24; v < 28; v++) begin
			vid = 5'(v);
			xl(v != 26);
			if (v != 26)
				chk_dat(pid, W6[16 * (v - 24) +: 16]);
		end
		vid = 5'h18;
		fr1 = 1'h0;
		xl(1'h0);
		e0en = 1'h1;
		xl(1'h1);
		e2 = 1'h0;
		xl(1'h0);
		e2 = 1'h1;
		xl(1'h1);
		// mid-run reset must clear the registered hit while the lookup still matches
		rst = 1'h1;
		@(negedge clock);
		chk_dat({resp_valid, hit}, 64'h0);
		rst = 1'h0;
		xl(1'h1);
		wrap_up;
	end
endmodule

// *** tb/vpm_core_model.sv ***
// vpm_core_model: core side issuing map register instructions one at a time
// assumes: the block takes a request on the rising edge and answers one cycle later
`timescale 1ns/1ns
module vpm_core_model (
	// clock
	input wire logic clock,
	// access request
	output logic acc_valid,
	output logic acc_write,
	output logic [2:0] acc_index,
	output logic [63:0] acc_wdata
);
	initial begin
		acc_valid = '0;
		acc_write = '0;
		acc_index = '0;
		acc_wdata = '0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// qualifiers are inverted once released, so a stale value can never pass for a match
	task automatic issue(input logic w, input logic [2:0] i, input logic [63:0] d);
		@(negedge clock);
		acc_valid = 1'h1;
		acc_write = w;
		acc_index = i;
		acc_wdata = d;
		@(negedge clock);
		acc_valid = 1'h0;
		acc_write = ~w;
		acc_index = ~i;
		acc_wdata = ~d;
	endtask
	// back-to-back write then read of one register, no idle cycle between them
	task automatic pair(input logic [2:0] i, input logic [63:0] d);
		@(negedge clock);
		acc_valid = 1'h1;
		acc_write = 1'h1;
		acc_index = i;
		acc_wdata = d;
		@(negedge clock);
		acc_write = 1'h0;
		@(negedge clock);
		acc_valid = 1'h0;
		acc_write = 1'h1;
		acc_index = ~i;
		acc_wdata = ~d;
	endtask
endmodule
